/* File: logic/irq_map.svh */
// Offsets, field positions, reset values and timing figures of the IRQ pin block.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
// Notes on behaviour
// - Bits 31:24 hold the holdoff interval, counted in 10 us steps.
// - Interval resets to zero; zero stops the counter and forwards pending interrupts.
// - A new non-zero interval applies to every interval started after the write.
// - Power event interrupt bypasses the holdoff and is never delayed.
// - Writing one to bit 14 restarts a fresh interval; the bit self-clears.
// - Bit 13 reads one while an interval withholds interrupts from the pin.
// - Bit 12 mirrors the master line of the enabled ordinary sources, ignoring enable, holdoff and the power event.
// - Bit 8 gates the pin; clear keeps the pin deasserted, status untouched.
// - Bit 4 picks push-pull polarity: zero active low, one active high.
// - Open-drain mode ignores polarity and is always active low.
// - Bit 0 picks buffer: zero open-drain, one push-pull.
// - Polarity and buffer bits survive soft and digital reset requests.
`ifndef IRQ_OUT_MAP_SVH
`define IRQ_OUT_MAP_SVH

// Register offsets
`define CFG_OFS         12'h054
`define STS_OFS         12'h100
`define CLR_OFS         12'h104
`define ENA_OFS         12'h108

// Field positions of the pin configuration word, then the pin level bit of the status word
`define DEAS_HI         31
`define DEAS_LO         24
`define CLR_BIT         14
`define ACT_BIT         13
`define INT_BIT         12
`define EN_BIT          8
`define POL_BIT         4
`define TYPE_BIT        0
`define PINLVL_BIT      31

// Reset values
`define DEAS_RST        8'h00
`define CFG_BIT_RST     1'b0

// Timing
`define HOLDOFF_UNIT_NS 10000
`define CLK_PERIOD_NS   25

`endif

/* File: logic/irq_pkg.sv */
// Types shared by the IRQ pin block and its holdoff timer.
// Assumes the constants header is included by the users of these types.
package irq_pkg;

   typedef logic [7:0]  interval_t;
   typedef logic [15:0] prescale_t;

   typedef enum logic [0:0] {
      TMR_IDLE = 1'b0,
      TMR_RUN  = 1'b1
   } tmr_state_e;

   typedef struct packed {
      tmr_state_e state;
      prescale_t  pre;
      interval_t  cnt;
   } tmr_s;

endpackage : irq_pkg

/* File: logic/holdoff_if.sv */
// Control link between the pin logic and the holdoff timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface holdoff_if;
   logic               start;
   logic               abort;
   irq_pkg::interval_t interval;
   logic               active;

   modport ctrl (output start, output abort, output interval, input active);
   modport timer (input start, input abort, input interval, output active);
endinterface : holdoff_if

/* File: logic/holdoff_timer.sv */
// Holdoff interval timer: prescaler to a 10 us tick, then a tick counter.
// Assumes start and abort are synchronous single-cycle or level requests.
`timescale 1ns/1ps

module holdoff_timer #(
   parameter int unsigned TICK_CYCLES = 400
) (
   input wire logic clk,
   input wire logic rst_n,
   holdoff_if.timer hif
);

   localparam irq_pkg::prescale_t PRE_LAST = irq_pkg::prescale_t'(TICK_CYCLES - 1);
   localparam irq_pkg::tmr_s      T_RST    = '{state: irq_pkg::TMR_IDLE, default: '0};

   irq_pkg::tmr_s t_r;
   irq_pkg::tmr_s t_nxt;

   // Next state of prescaler and tick counter
   always_comb begin
      t_nxt = t_r;
      if (hif.abort) begin
         t_nxt = T_RST;
      end else if (hif.start) begin
         t_nxt.state = irq_pkg::TMR_RUN;
         t_nxt.cnt   = hif.interval;
         t_nxt.pre   = '0;
      end else if (t_r.state == irq_pkg::TMR_RUN) begin
         if (t_r.pre == PRE_LAST) begin
            t_nxt.pre = '0;
            t_nxt.cnt = t_r.cnt - 8'h01;
            if (t_r.cnt == 8'h01) begin
               t_nxt.state = irq_pkg::TMR_IDLE;
            end
         end else begin
            t_nxt.pre = t_r.pre + 16'h0001;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_r <= T_RST;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign hif.active = (t_r.state == irq_pkg::TMR_RUN);

   default clocking tcb @(posedge clk); endclocking
   default disable iff (!rst_n);

   tmr_load_a: assert property (hif.start && !hif.abort |=> hif.active && t_r.cnt == $past(hif.interval))
      else $error("Timer did not load the new interval");
   tmr_live_a: assert property (hif.active |-> t_r.cnt != 8'h00 && t_r.pre <= PRE_LAST)
      else $error("Timer running with empty count");

endmodule : holdoff_timer

/* File: logic/irq_output_config.sv */
// Interrupt request pin conditioning: sticky sources, holdoff interval, pin buffer.
// Assumes a single 40 MHz clock and a register master that never waits.
`timescale 1ns/1ps
`include "irq_map.svh"

module irq_output_config #(
   parameter int unsigned NSRC = 8
) (
   input  wire logic            core_clk,
   input  wire logic            rstn,
   input  wire logic [11:0]     addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr_stb,
   input  wire logic            rd_stb,
   output logic      [31:0]     rdata,
   input  wire logic [NSRC-1:0] src_event,
   input  wire logic            power_event_interrupt,
   input  wire logic            soft_reset_request,
   input  wire logic            digital_reset_request,
   input  wire logic            irq_pin_in,
   output logic                 irq_pin_out,
   output logic                 irq_pin_oe
);

   // ----------------------------------------------------------------
   // Constants and state
   // ----------------------------------------------------------------

   localparam int unsigned HOLDOFF_TICKS =
      (`HOLDOFF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   typedef struct packed {
      irq_pkg::interval_t deas;
      logic               en;
      logic               pol;
      logic               typ;
      logic [NSRC:0]      sts;
      logic [NSRC:0]      ena;
      logic               deliv_prev;
      logic [31:0]        rdata;
      logic               pin_out;
      logic               pin_oe;
   } st_s;

   localparam st_s ST_RST = '{
      deas:    `DEAS_RST,
      en:      `CFG_BIT_RST,
      pol:     `CFG_BIT_RST,
      typ:     `CFG_BIT_RST,
      default: '0
   };

   st_s        s_r;
   st_s        s_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;

   holdoff_if hif ();

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------

   // Two-stage release of the asynchronous reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------

   // Configuration word as software reads it; clear bit always reads zero
   function automatic logic [31:0] cfg_word(
      input irq_pkg::interval_t deas,
      input logic               act,
      input logic               mint,
      input logic               en,
      input logic               pol,
      input logic               typ
   );
      logic [31:0] w;
      w                       = '0;
      w[`DEAS_HI:`DEAS_LO]    = deas;
      w[`ACT_BIT]             = act;
      w[`INT_BIT]             = mint;
      w[`EN_BIT]              = en;
      w[`POL_BIT]             = pol;
      w[`TYPE_BIT]            = typ;
      return w;
   endfunction : cfg_word

   // ----------------------------------------------------------------
   // Combined line and holdoff control
   // ----------------------------------------------------------------

   logic            irq_int;
   logic            pme_on;
   logic            deliv;
   logic            line;
   logic            cfg_wr;
   logic            clr_req;
   logic            soft_rst;
   logic [NSRC:0]   ev;
   logic [NSRC:0]   clr_mask;

   // Enabled sources merged into the master line
   always_comb begin
      irq_int  = |(s_r.sts[NSRC-1:0] & s_r.ena[NSRC-1:0]);
      pme_on   = s_r.sts[NSRC] & s_r.ena[NSRC];
      deliv    = irq_int & !hif.active;
      line     = (deliv | pme_on) & s_r.en;
      cfg_wr   = wr_stb && (addr == `CFG_OFS);
      clr_req  = cfg_wr && wdata[`CLR_BIT];
      soft_rst = soft_reset_request | digital_reset_request;
      ev       = {power_event_interrupt, src_event};
      clr_mask = (wr_stb && (addr == `CLR_OFS)) ? wdata[NSRC:0] : '0;
   end

   // Interval starts when the delivered line drops, or on a clear write
   assign hif.start    = (s_r.deas != `DEAS_RST) &&
                         ((s_r.deliv_prev && !irq_int) || clr_req);
   assign hif.abort    = (s_r.deas == `DEAS_RST) || soft_rst;
   assign hif.interval = s_r.deas;

   holdoff_timer #(
      .TICK_CYCLES (HOLDOFF_TICKS)
   ) u_timer (
      .clk   (core_clk),
      .rst_n (rst_n),
      .hif   (hif)
   );

   // ----------------------------------------------------------------
   // Register file, status and pin
   // ----------------------------------------------------------------

   // Next state of registers, sticky status and the pin drivers
   always_comb begin
      s_nxt            = s_r;
      s_nxt.deliv_prev = deliv;

      // Configuration write
      if (cfg_wr) begin
         s_nxt.deas = wdata[`DEAS_HI:`DEAS_LO];
         s_nxt.en   = wdata[`EN_BIT];
         s_nxt.pol  = wdata[`POL_BIT];
         s_nxt.typ  = wdata[`TYPE_BIT];
      end
      if (wr_stb && (addr == `ENA_OFS)) begin
         s_nxt.ena = wdata[NSRC:0];
      end

      // Sticky status: a new event wins over a clear in the same cycle
      s_nxt.sts = (s_r.sts & ~clr_mask) | ev;

      // Read data stand one cycle after the strobe and only then
      s_nxt.rdata = '0;
      if (rd_stb) begin
         unique case (addr)
            `CFG_OFS: s_nxt.rdata = cfg_word(s_r.deas, hif.active, irq_int,
                                             s_r.en, s_r.pol, s_r.typ);
            `STS_OFS: begin
               s_nxt.rdata              = 32'(s_r.sts);
               s_nxt.rdata[`PINLVL_BIT] = irq_pin_in;
            end
            `ENA_OFS: s_nxt.rdata = 32'(s_r.ena);
            default:  s_nxt.rdata = '0;
         endcase
      end

      // Pin buffer and polarity
      if (s_r.typ) begin
         s_nxt.pin_oe  = 1'b1;
         s_nxt.pin_out = s_r.pol ? line : !line;
      end else begin
         s_nxt.pin_oe  = line;
         s_nxt.pin_out = 1'b0;
      end

      // Soft or digital reset keeps polarity and buffer type
      if (soft_rst) begin
         s_nxt.deas       = `DEAS_RST;
         s_nxt.en         = `CFG_BIT_RST;
         s_nxt.sts        = '0;
         s_nxt.ena        = '0;
         s_nxt.deliv_prev = 1'b0;
         s_nxt.pol        = s_r.pol;
         s_nxt.typ        = s_r.typ;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata       = s_r.rdata;
   assign irq_pin_out = s_r.pin_out;
   assign irq_pin_oe  = s_r.pin_oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Helper: length of the last holdoff run and its programmed interval
   int unsigned        run_cnt;
   irq_pkg::interval_t run_iv;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_cnt <= 0;
         run_iv  <= `DEAS_RST;
      end else if (hif.start) begin
         run_cnt <= 0;
         run_iv  <= hif.interval;
      end else if (hif.active) begin
         run_cnt <= run_cnt + 1;
      end
   end

   // Pin at its deasserted level for the buffer mode one cycle earlier
   sequence pin_quiet;
      $past(s_r.typ) ? (irq_pin_oe && irq_pin_out == !$past(s_r.pol)) : !irq_pin_oe;
   endsequence

   sequence interval_end;
      $fell(hif.active) && !$past(hif.abort);
   endsequence

   sequence pending_high;
      irq_int && s_r.en && s_r.typ && s_r.pol;
   endsequence

   sequence pin_high;
      irq_pin_oe && irq_pin_out;
   endsequence

   interval_len_a: assert property (
      interval_end |-> run_cnt == run_iv * HOLDOFF_TICKS)
      else $error("Holdoff length differs from interval times tick");

   zero_abort_a: assert property (
      s_r.deas == `DEAS_RST |=> !hif.active)
      else $error("Interval still running with zero setting");

   new_iv_a: assert property (
      hif.start && !hif.abort |=> run_iv == $past(s_r.deas) && hif.active)
      else $error("Interval not taken from current setting");

   pme_bypass_a: assert property (
      pme_on && s_r.en && !s_r.typ |=> irq_pin_oe && !irq_pin_out)
      else $error("Power event withheld from pin");

   clr_restart_a: assert property (
      clr_req && !soft_rst && s_r.deas != `DEAS_RST |=> hif.active)
      else $error("Clear bit did not restart interval");

   act_flag_a: assert property (
      rd_stb && addr == `CFG_OFS |=> rdata[`ACT_BIT] == $past(hif.active)
                                     && !rdata[`CLR_BIT])
      else $error("Holdoff flag readback wrong");

   master_bit_a: assert property (
      rd_stb && addr == `CFG_OFS |=> rdata[`INT_BIT] == $past(irq_int))
      else $error("Master line readback wrong");

   pin_gate_a: assert property (
      !s_r.en |=> pin_quiet)
      else $error("Pin asserted while output disabled");

   pol_pp_a: assert property (
      s_r.typ && line |=> irq_pin_oe && irq_pin_out == $past(s_r.pol))
      else $error("Push-pull polarity wrong");

   od_low_a: assert property (
      !s_r.typ |=> !irq_pin_out && irq_pin_oe == $past(line))
      else $error("Open-drain pin not active low");

   pp_drive_a: assert property (
      s_r.typ |=> irq_pin_oe)
      else $error("Push-pull pin not driven");

   soft_keep_a: assert property (
      soft_rst |=> s_r.pol == $past(s_r.pol) && s_r.typ == $past(s_r.typ)
                   && s_r.deas == `DEAS_RST && !s_r.en)
      else $error("Soft reset lost pin setup or kept interval");

   expire_pin_a: assert property (
      interval_end ##0 pending_high |=> pin_high)
      else $error("Pending interrupt not issued at interval end");

   rd_once_a: assert property (
      rd_stb ##1 !rd_stb |=> rdata == '0)
      else $error("Read data held beyond one cycle");

   // Register side: a new event beats a clear
   sts_sticky_a: assert property (!soft_rst |=> (s_r.sts & $past(ev)) == $past(ev))
      else $error("Event lost against a status clear");

   // Configuration write lands in one cycle
   cfg_wr_a: assert property (
      cfg_wr && !soft_rst |=> s_r.en == $past(wdata[`EN_BIT])
                              && s_r.deas == $past(wdata[`DEAS_HI:`DEAS_LO]))
      else $error("Configuration write not taken");

   // Unmapped reads return zero
   unmapped_rd_a: assert property (
      rd_stb && addr != `CFG_OFS && addr != `STS_OFS && addr != `ENA_OFS |=> rdata == '0)
      else $error("Unmapped read returned data");

   // Holdoff side: soft reset stops the timer and empties status
   soft_abort_a: assert property (soft_rst |=> !hif.active && s_r.sts == '0)
      else $error("Soft reset left interval or status");

   // Serviced interrupt opens an interval
   start_edge_a: assert property (
      s_r.deliv_prev && !irq_int && s_r.deas != `DEAS_RST && !soft_rst |=> hif.active)
      else $error("Serviced interrupt did not open an interval");

   // Pin stays quiet while an interval withholds ordinary sources
   held_off_a: assert property (hif.active && !pme_on |=> pin_quiet)
      else $error("Pin asserted during holdoff interval");

   // Zero interval lets a pending interrupt straight through
   zero_pass_a: assert property (
      s_r.deas == `DEAS_RST ##1 s_r.deas == `DEAS_RST ##0 pending_high |=> pin_high)
      else $error("Zero interval withheld a pending interrupt");

endmodule : irq_output_config

/* File: test/irq_host_model.sv */
// Host side of the interrupt request wire: pull-up plus level sensing.
// Assumes the bench tells it which level the pin asserts at.
`timescale 1ns/1ps

module irq_host_model (
   input  wire logic irq_pin_out,
   input  wire logic irq_pin_oe,
   input  wire logic active_high,
   output logic      wire_lvl,
   output logic      req
);
   // Pull-up keeps the shared wire high while nobody drives it
   assign wire_lvl = irq_pin_oe ? irq_pin_out : 1'b1;
   // Request seen at the configured active level
   assign req = active_high ? wire_lvl : ~wire_lvl;
endmodule : irq_host_model

/* File: test/tb.sv */
// Self-checking bench of the IRQ pin block against a model of its registers.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`include "irq_map.svh"
`define CHECK_EQ(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic        core_clk = 1'b0;
   logic        rstn;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] rdata;
   logic [7:0]  src_event;
   logic        power_event_interrupt;
   logic        soft_reset_request;
   logic        digital_reset_request;
   logic        irq_pin_in;
   logic        irq_pin_out;
   logic        irq_pin_oe;
   logic        host_req;
   logic [8:0]  m_sts;
   logic [8:0]  m_ena;
   logic [7:0]  m_iv;
   logic        m_en;
   logic        m_pol;
   logic        m_typ;
   logic [31:0] seed = 32'h8eaf;
   int          mismatches;
   int          checks_done;
   real         t0;

   // Design and host side of the wire
   irq_output_config #(.NSRC(8)) i_dut (.core_clk(core_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .src_event(src_event),
      .power_event_interrupt(power_event_interrupt), .soft_reset_request(soft_reset_request),
      .digital_reset_request(digital_reset_request), .irq_pin_in(irq_pin_in),
      .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
   irq_host_model i_host (.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
      .active_high(m_typ & m_pol), .wire_lvl(irq_pin_in), .req(host_req));

   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;

   // ----------------------------------------
   // Model and bus helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic master();
      return |(m_sts[7:0] & m_ena[7:0]);
   endfunction : master

   function automatic logic [31:0] cfg_exp(input logic hold);
      return {m_iv, 10'h0, hold, master(), 3'h0, m_en, 3'h0, m_pol, 3'h0, m_typ};
   endfunction : cfg_exp

   function automatic logic [31:0] cfg_word(input logic clr);
      return {m_iv, 9'h0, clr, 5'h0, m_en, 3'h0, m_pol, 3'h0, m_typ};
   endfunction : cfg_word

   // Expected {oe, out} of the pin
   function automatic logic [1:0] pin_exp(input logic hold);
      logic l;
      l = ((master() & ~hold) | (m_sts[8] & m_ena[8])) & m_en;
      return m_typ ? {1'b1, m_pol ? l : ~l} : {l, 1'b0};
   endfunction : pin_exp

   function automatic logic [31:0] sts_exp(input logic hold);
      logic [1:0] p;
      p = pin_exp(hold);
      return {p[1] ? p[0] : 1'b1, 22'h0, m_sts};
   endfunction : sts_exp

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      `CHECK_EQ(rdata, e)
   endtask : rd_chk

   task automatic set_cfg(input logic [7:0] iv, input logic en, pol, typ);
      m_iv = iv;
      m_en = en;
      m_pol = pol;
      m_typ = typ;
      wr(`CFG_OFS, cfg_word(1'b0));
   endtask : set_cfg

   task automatic pulse(input logic [7:0] s, input logic p);
      @(posedge core_clk);
      src_event <= s;
      power_event_interrupt <= p;
      @(posedge core_clk);
      src_event <= 8'h00;
      power_event_interrupt <= 1'b0;
      m_sts = m_sts | {p, s};
      repeat (2) @(posedge core_clk);
      #1;
   endtask : pulse

   task automatic clr(input logic [8:0] m);
      wr(`CLR_OFS, {23'h0, m});
      m_sts = m_sts & ~m;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : clr

   task automatic wait_req(input int max, output int n);
      n = 0;
      while (host_req !== 1'b1) begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > max) begin
            mismatches++;
            $display("[FAIL] %0t wait for pin ran out", $time);
            complete_run();
         end
      end
   endtask : wait_req

   // Serviced interrupt, then a withheld one, optionally restarted
   task automatic holdoff_run(input logic [7:0] iv, input bit restart);
      int n;
      set_cfg(iv, 1'b1, 1'b1, 1'b1);
      pulse(8'h01, 1'b0);
      `CHECK_EQ(host_req, 1'b1)
      wr(`CLR_OFS, 32'h1);
      m_sts = 9'h000;
      t0 = $realtime;
      pulse(8'h02, 1'b0);
      `CHECK_EQ({irq_pin_oe, irq_pin_out}, pin_exp(1'b1))
      rd_chk(`CFG_OFS, cfg_exp(1'b1));
      if (restart) begin
         repeat (200) @(posedge core_clk);
         wr(`CFG_OFS, cfg_word(1'b1));
         t0 = $realtime;
      end
      wait_req(iv * 400 + 20, n);
      n = int'(($realtime - t0) / 25.0);
      `CHECK_EQ(n >= iv * 400 && n <= iv * 400 + 5, 1'b1)
      rd_chk(`CFG_OFS, cfg_exp(1'b0));
      set_cfg(8'h00, 1'b1, 1'b1, 1'b1);
      clr(9'h1ff);
      $display("test holdoff %0d restart %0d done", iv, restart);
   endtask : holdoff_run

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      rstn = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      src_event = 8'h00;
      power_event_interrupt = 1'b0;
      soft_reset_request = 1'b0;
      digital_reset_request = 1'b0;
      {m_sts, m_ena, m_iv, m_en, m_pol, m_typ} = '0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      // Reset values, unmapped place
      rd_chk(`CFG_OFS, 32'h0);
      rd_chk(`STS_OFS, sts_exp(1'b0));
      wr(12'h3f0, 32'hffff_ffff);
      rd_chk(12'h3f0, 32'h0);
      `CHECK_EQ({irq_pin_oe, irq_pin_out}, 2'b00)
      $display("test reset done");
      // Every enable, polarity and buffer setting with a pending source
      m_ena = 9'h1ff;
      wr(`ENA_OFS, 32'h1ff);
      pulse(8'h10, 1'b0);
      for (int k = 0; k < 8; k++) begin
         set_cfg(8'h00, k[2], k[1], k[0]);
         repeat (2) @(posedge core_clk);
         #1;
         `CHECK_EQ({irq_pin_oe, irq_pin_out}, pin_exp(1'b0))
         rd_chk(`STS_OFS, sts_exp(1'b0));
         rd_chk(`CFG_OFS, cfg_exp(1'b0));
      end
      clr(9'h1ff);
      $display("test pin modes done");
      // Random sources and enables with the pin gated off
      set_cfg(8'h00, 1'b0, 1'b1, 1'b1);
      for (int k = 0; k < 6; k++) begin
         r = xs();
         m_ena = r[8:0];
         wr(`ENA_OFS, {23'h0, m_ena});
         pulse(r[16:9], 1'b0);
         rd_chk(`STS_OFS, sts_exp(1'b0));
         rd_chk(`ENA_OFS, {23'h0, m_ena});
         rd_chk(`CFG_OFS, cfg_exp(1'b0));
         clr(r[26:18]);
         rd_chk(`STS_OFS, sts_exp(1'b0));
      end
      clr(9'h1ff);
      m_ena = 9'h1ff;
      wr(`ENA_OFS, 32'h1ff);
      $display("test random done");
      // Interval lengths and restart
      holdoff_run(8'h01, 1'b0);
      holdoff_run(8'h02, 1'b0);
      holdoff_run(8'h01, 1'b1);
      // Power event bypass, then interval zero releases the pending one
      set_cfg(8'h03, 1'b1, 1'b0, 1'b0);
      pulse(8'h01, 1'b0);
      clr(9'h001);
      pulse(8'h00, 1'b1);
      `CHECK_EQ({irq_pin_oe, irq_pin_out}, pin_exp(1'b1))
      clr(9'h100);
      pulse(8'h04, 1'b0);
      `CHECK_EQ({irq_pin_oe, irq_pin_out}, pin_exp(1'b1))
      set_cfg(8'h00, 1'b1, 1'b0, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      `CHECK_EQ({irq_pin_oe, irq_pin_out}, 2'b10)
      rd_chk(`CFG_OFS, cfg_exp(1'b0));
      clr(9'h1ff);
      $display("test bypass done");
      // Soft and digital reset requests keep polarity and buffer type
      for (int k = 0; k < 2; k++) begin
         set_cfg(8'h03, 1'b1, 1'b1, 1'b1);
         @(posedge core_clk);
         soft_reset_request <= (k == 0);
         digital_reset_request <= (k == 1);
         @(posedge core_clk);
         soft_reset_request <= 1'b0;
         digital_reset_request <= 1'b0;
         {m_sts, m_ena, m_iv, m_en} = '0;
         rd_chk(`CFG_OFS, cfg_exp(1'b0));
         rd_chk(`ENA_OFS, 32'h0);
         `CHECK_EQ({irq_pin_oe, irq_pin_out}, 2'b10)
      end
      $display("test soft reset done");
      complete_run();
   end
endmodule : tb
